// ==== inc/gpw_pkg.sv ====
package gpw_pkg;
  // register offsets inside the special function area
  localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
  localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h01;
  localparam logic [7:0] OFS_PORT_C_DATA = 8'h02;
  localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h03;
  localparam logic [7:0] OFS_PORT_D_DATA = 8'h04;
  localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h05;
  localparam logic [7:0] OFS_PORT_E_DATA = 8'h06;
  localparam logic [7:0] OFS_PORT_E_DIRECTION = 8'h07;
  localparam logic [7:0] OFS_PIN_INTERRUPT_CTRL_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PORT_A_WAKE_ENABLE = 8'h09;

  // reset values
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  localparam logic [2:0] MF_EN_RST = 3'h0;
  localparam logic [2:0] MF_FLAG_RST = 3'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // pin interrupt control/flag register fields
  localparam int MF_EN_LSB = 0;
  localparam int MF_FLAG_LSB = 4;

  // port c lines feeding the pin interrupt
  localparam int MF_SRC0_BIT = 0;
  localparam int MF_SRC1_BIT = 5;
  localparam int MF_SRC2_BIT = 7;

  // port c lines that are open-drain outputs only (bits 2 and 3)
  localparam logic [7:0] PORT_C_OPENDRAIN_MASK = 8'h0c;
  localparam logic [7:0] NO_OPENDRAIN_MASK = 8'h00;

  // pull-high option bit positions
  localparam int PULL_A = 0;
  localparam int PULL_C = 1;
  localparam int PULL_D = 2;
  localparam int PULL_E = 3;
endpackage

// ==== inc/gpw_bank_if.sv ====
`timescale 1ns/1ps
interface gpw_bank_if #(parameter int W = 8);
  logic wr_data;
  logic wr_dir;
  logic [7:0] wdata;
  logic [W-1:0] view;
  logic [W-1:0] fall;
  modport ctl (output wr_data, output wr_dir, output wdata, input view, input fall);
  modport bank (input wr_data, input wr_dir, input wdata, output view, output fall);
endinterface

// ==== design/gpw_pin_bank.sv ====
`timescale 1ns/1ps
module gpw_pin_bank #(
  parameter int W = 8,
  parameter logic [7:0] OD_MASK = 8'h00
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // configuration option
  input wire logic pull_opt_i,
  // register side
  gpw_bank_if.bank bus,
  // pins
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] pin_pull_o
);
  logic [W-1:0] data_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] hist_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] pull_reg;
  wire [W-1:0] od = OD_MASK[W-1:0];
  wire [W-1:0] rst_ones = gpw_pkg::PORT_RST[W-1:0];
  wire [W-1:0] in_sel = dir_reg & ~od;

  // input bits show the synced pin, output and open-drain bits the latch
  assign bus.view = (in_sel & sync2_reg) | (~in_sel & data_reg);
  assign bus.fall = hist_reg & ~sync2_reg;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      data_reg <= rst_ones;
      dir_reg <= rst_ones;
    end
    else
    begin
      if (bus.wr_data)
        data_reg <= bus.wdata[W-1:0];
      if (bus.wr_dir)
        dir_reg <= bus.wdata[W-1:0];
    end
  end

  // inputs are not latched; the sample is only two flops old at read time
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= rst_ones;
      sync2_reg <= rst_ones;
      hist_reg <= rst_ones;
    end
    else
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      hist_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      out_reg <= rst_ones & ~od;
      oe_reg <= '0;
      pull_reg <= '0;
    end
    else
    begin
      out_reg <= data_reg & ~od;
      oe_reg <= (~dir_reg & ~od) | (od & ~data_reg);
      pull_reg <= {W{pull_opt_i}} & dir_reg & ~od;
    end
  end

  assign pin_o = out_reg;
  assign pin_oe_o = oe_reg;
  assign pin_pull_o = pull_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_RESET_ONES: assert property (
    $past(!nrst_i) |-> data_reg == rst_ones && dir_reg == rst_ones)
    else $error("port registers not all ones after reset");
  AST_LATCH_HOLD: assert property (!bus.wr_data |=> $stable(data_reg))
    else $error("output latch changed without a write");
  AST_PUSH_PULL: assert property ($past(nrst_i) |->
    ((pin_oe_o & ~od) == ($past(~dir_reg) & ~od))
    && ((pin_o & ~od) == ($past(data_reg) & ~od)))
    else $error("push-pull pin does not follow direction and latch");
  AST_OPEN_DRAIN: assert property ($past(nrst_i) |-> (pin_o & od) == '0
    && (pin_oe_o & od) == ($past(~data_reg) & od))
    else $error("open-drain line drives high or ignores its latch");
  AST_PULL_INPUT_ONLY: assert property ((pin_pull_o & ~$past(dir_reg)) == '0)
    else $error("pull-high on a pin that is not an input");
  AST_INPUT_VIEW: assert property ((in_sel == '1) |-> bus.view == $past(sync1_reg))
    else $error("input read does not return the sampled pin");
endmodule

// ==== design/gpw_port_top.sv ====
`timescale 1ns/1ps
// How it works
// - twenty-six two-way lines over ports a, c, d, e; data and direction bits
// - direction bit one: pin is input, read returns pin level
// - direction bit zero: pin driven push-pull from its data latch
// - reading an output pin returns the latch, not the pin level
// - inputs unlatched; the source holds the level while the read samples it
// - written output data stays in the latch until rewritten
// - port c lines two and three are open-drain outputs only
// - reset sets every data and direction register to all ones
// - pin turned to output before a data write drives high
// - single-bit set or clear reads the port, changes one bit, writes byte back
// - pull-high only on input pins, chosen per whole port
// - during halt a wake-enabled port a pin falling wakes the device
// - wake enable is per port a pin, any combination allowed
// - port c lines zero, five, seven raise interrupt; enables in bits 0 to 2
// - cause flags for those lines sit in bits 4 to 6
// - data and direction registers reachable regardless of memory bank
module gpw_port_top #(
  parameter int PE_W = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // special function register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_bitop_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic sfr_bit_val_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // configuration options and power control
  input wire logic [3:0] pull_opt_i,
  input wire logic halt_i,
  output logic wake_o,
  output logic mf_req_o,
  // port a pins
  input wire logic [7:0] port_a_data_i,
  output logic [7:0] port_a_data_o,
  output logic [7:0] port_a_data_oe_o,
  output logic [7:0] port_a_pull_o,
  // port c pins, bits 2 and 3 open-drain
  input wire logic [7:0] port_c_data_i,
  output logic [7:0] port_c_data_o,
  output logic [7:0] port_c_data_oe_o,
  output logic [7:0] port_c_pull_o,
  // port d pins
  input wire logic [7:0] port_d_data_i,
  output logic [7:0] port_d_data_o,
  output logic [7:0] port_d_data_oe_o,
  output logic [7:0] port_d_pull_o,
  // port e pins
  input wire logic [PE_W-1:0] port_e_data_i,
  output logic [PE_W-1:0] port_e_data_o,
  output logic [PE_W-1:0] port_e_data_oe_o,
  output logic [PE_W-1:0] port_e_pull_o
);
  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  gpw_bank_if #(.W(8)) a_if ();
  gpw_bank_if #(.W(8)) c_if ();
  gpw_bank_if #(.W(8)) d_if ();
  gpw_bank_if #(.W(PE_W)) e_if ();

  logic [7:0] wake_en_reg;
  logic [2:0] mf_en_reg;
  logic [2:0] mf_flag_reg;
  logic [2:0] mf_en_next;
  logic [2:0] mf_flag_next;
  logic wake_reg;
  logic mf_req_reg;
  logic [7:0] rdata_reg;

  // address decode; the flat offsets ignore any bank pointer
  wire sel_a_data = hit(sfr_addr_i, gpw_pkg::OFS_PORT_A_DATA);
  wire sel_a_dir = hit(sfr_addr_i, gpw_pkg::OFS_PORT_A_DIRECTION);
  wire sel_c_data = hit(sfr_addr_i, gpw_pkg::OFS_PORT_C_DATA);
  wire sel_c_dir = hit(sfr_addr_i, gpw_pkg::OFS_PORT_C_DIRECTION);
  wire sel_d_data = hit(sfr_addr_i, gpw_pkg::OFS_PORT_D_DATA);
  wire sel_d_dir = hit(sfr_addr_i, gpw_pkg::OFS_PORT_D_DIRECTION);
  wire sel_e_data = hit(sfr_addr_i, gpw_pkg::OFS_PORT_E_DATA);
  wire sel_e_dir = hit(sfr_addr_i, gpw_pkg::OFS_PORT_E_DIRECTION);
  wire sel_mf = hit(sfr_addr_i, gpw_pkg::OFS_PIN_INTERRUPT_CTRL_FLAGS);
  wire sel_wake = hit(sfr_addr_i, gpw_pkg::OFS_PORT_A_WAKE_ENABLE);

  wire [7:0] e_view8 = 8'(e_if.view);
  wire [7:0] e_dir8 = 8'({PE_W{1'b1}});
  wire [7:0] mf_view = {1'b0, mf_flag_reg, 1'b0, mf_en_reg};

  // direction registers read back as stored; copies kept here, the bank does not expose them
  logic [7:0] a_dir_copy;
  logic [7:0] c_dir_copy;
  logic [7:0] d_dir_copy;
  logic [7:0] e_dir_copy;

  wire [7:0] rd_val =
    sel_a_data ? a_if.view :
    sel_c_data ? c_if.view :
    sel_d_data ? d_if.view :
    sel_e_data ? e_view8 :
    sel_a_dir ? a_dir_copy :
    sel_c_dir ? c_dir_copy :
    sel_d_dir ? d_dir_copy :
    sel_e_dir ? e_dir_copy :
    sel_mf ? mf_view :
    sel_wake ? wake_en_reg :
    8'h00;

  // a bit op writes back the whole byte as read, so input pins load their
  // current level into the latch; a plain write wins over a bit op
  wire [7:0] bit_mod = put_bit(rd_val, sfr_bit_idx_i, sfr_bit_val_i);
  wire wr_go = sfr_wr_i | sfr_bitop_i;
  wire [7:0] wdata_eff = sfr_wr_i ? sfr_wdata_i : bit_mod;

  assign a_if.wr_data = wr_go & sel_a_data;
  assign a_if.wr_dir = wr_go & sel_a_dir;
  assign a_if.wdata = wdata_eff;
  assign c_if.wr_data = wr_go & sel_c_data;
  assign c_if.wr_dir = wr_go & sel_c_dir;
  assign c_if.wdata = wdata_eff;
  assign d_if.wr_data = wr_go & sel_d_data;
  assign d_if.wr_dir = wr_go & sel_d_dir;
  assign d_if.wdata = wdata_eff;
  assign e_if.wr_data = wr_go & sel_e_data;
  assign e_if.wr_dir = wr_go & sel_e_dir;
  assign e_if.wdata = wdata_eff;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      a_dir_copy <= gpw_pkg::PORT_RST;
      c_dir_copy <= gpw_pkg::PORT_RST;
      d_dir_copy <= gpw_pkg::PORT_RST;
      e_dir_copy <= gpw_pkg::PORT_RST & e_dir8;
    end
    else
    begin
      if (a_if.wr_dir)
        a_dir_copy <= wdata_eff;
      if (c_if.wr_dir)
        c_dir_copy <= wdata_eff;
      if (d_if.wr_dir)
        d_dir_copy <= wdata_eff;
      if (e_if.wr_dir)
        e_dir_copy <= wdata_eff & e_dir8;
    end
  end

  gpw_pin_bank #(.W(8), .OD_MASK(gpw_pkg::NO_OPENDRAIN_MASK)) u_bank_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pull_opt_i(pull_opt_i[gpw_pkg::PULL_A]),
    .bus(a_if.bank),
    .pin_i(port_a_data_i),
    .pin_o(port_a_data_o),
    .pin_oe_o(port_a_data_oe_o),
    .pin_pull_o(port_a_pull_o)
  );

  // input bits 2 and 3 of port c are ignored: those lines are output only
  gpw_pin_bank #(.W(8), .OD_MASK(gpw_pkg::PORT_C_OPENDRAIN_MASK)) u_bank_c (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pull_opt_i(pull_opt_i[gpw_pkg::PULL_C]),
    .bus(c_if.bank),
    .pin_i(port_c_data_i),
    .pin_o(port_c_data_o),
    .pin_oe_o(port_c_data_oe_o),
    .pin_pull_o(port_c_pull_o)
  );

  gpw_pin_bank #(.W(8), .OD_MASK(gpw_pkg::NO_OPENDRAIN_MASK)) u_bank_d (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pull_opt_i(pull_opt_i[gpw_pkg::PULL_D]),
    .bus(d_if.bank),
    .pin_i(port_d_data_i),
    .pin_o(port_d_data_o),
    .pin_oe_o(port_d_data_oe_o),
    .pin_pull_o(port_d_pull_o)
  );

  gpw_pin_bank #(.W(PE_W), .OD_MASK(gpw_pkg::NO_OPENDRAIN_MASK)) u_bank_e (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pull_opt_i(pull_opt_i[gpw_pkg::PULL_E]),
    .bus(e_if.bank),
    .pin_i(port_e_data_i),
    .pin_o(port_e_data_o),
    .pin_oe_o(port_e_data_oe_o),
    .pin_pull_o(port_e_pull_o)
  );

  // wake on a falling edge of any enabled port a line while halted
  wire [7:0] wake_hits = a_if.fall & wake_en_reg;
  wire wake_hit = halt_i & (|wake_hits);

  // pin interrupt sources: falling edges on port c lines zero, five, seven
  wire [2:0] mf_src = {c_if.fall[gpw_pkg::MF_SRC2_BIT], c_if.fall[gpw_pkg::MF_SRC1_BIT],
                       c_if.fall[gpw_pkg::MF_SRC0_BIT]};
  wire [2:0] mf_event = mf_src & mf_en_reg;
  wire mf_wr = wr_go & sel_mf;
  wire mf_clr2 = mf_wr & ~wdata_eff[gpw_pkg::MF_FLAG_LSB + 2];
  wire [2:0] mf_keep = mf_wr ? wdata_eff[gpw_pkg::MF_FLAG_LSB +: 3] : 3'h7;

  // a new event in the clearing cycle survives: set wins over clear
  assign mf_flag_next = (mf_flag_reg & mf_keep) | mf_event;
  assign mf_en_next = mf_wr ? wdata_eff[gpw_pkg::MF_EN_LSB +: 3] : mf_en_reg;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      mf_en_reg <= gpw_pkg::MF_EN_RST;
      mf_flag_reg <= gpw_pkg::MF_FLAG_RST;
      mf_req_reg <= 1'b0;
    end
    else
    begin
      mf_en_reg <= mf_en_next;
      mf_flag_reg <= mf_flag_next;
      mf_req_reg <= |(mf_flag_next & mf_en_next);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wake_en_reg <= gpw_pkg::WAKE_EN_RST;
      wake_reg <= 1'b0;
    end
    else
    begin
      if (wr_go && sel_wake)
        wake_en_reg <= wdata_eff;
      wake_reg <= wake_hit;
    end
  end

  // read data registered one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_reg <= gpw_pkg::RDATA_RST;
    else if (sfr_rd_i)
      rdata_reg <= rd_val;
  end

  assign sfr_rdata_o = rdata_reg;
  assign wake_o = wake_reg;
  assign mf_req_o = mf_req_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_wake_cause;
    halt_i && (|(a_if.fall & wake_en_reg));
  endsequence

  // a clearing write with no competing event in the same cycle
  sequence s_mf_clear;
    mf_clr2 && !mf_event[2];
  endsequence

  AST_WAKE_ON_FALL: assert property (s_wake_cause |=> wake_o)
    else $error("enabled port a fall during halt did not wake");
  AST_NO_STRAY_WAKE: assert property (wake_o |-> $past(halt_i) && $past(|wake_hits))
    else $error("wake without an enabled falling line in halt");
  AST_FLAG_SET: assert property ((mf_src[0] && mf_en_reg[0]) ##1 1'b1 |->
    mf_flag_reg[0] && mf_req_o)
    else $error("cause flag zero not set by its event");
  AST_FLAG_STICKY: assert property (mf_flag_reg[2] && !mf_clr2 |=> mf_flag_reg[2])
    else $error("cause flag two dropped without a clearing write");
  AST_FLAG_CLEARS: assert property (s_mf_clear |=> !mf_flag_reg[2])
    else $error("cause flag two not cleared by a zero write");
  AST_REQ_NEEDS_ENABLE: assert property (mf_req_o |-> |(mf_flag_reg & mf_en_reg))
    else $error("pin interrupt request without an enabled flag");
  AST_BITOP_RMW: assert property (sfr_bitop_i && !sfr_wr_i && sel_wake |=>
    wake_en_reg == put_bit($past(rd_val), $past(sfr_bit_idx_i), $past(sfr_bit_val_i)))
    else $error("bit op did not write back the modified byte");
  AST_READ_LATENCY: assert property (sfr_rd_i && sel_mf |=>
    sfr_rdata_o == $past(mf_view))
    else $error("pin interrupt register read wrong");
  AST_OUTPUT_AFTER_RESET: assert property ($past(!nrst_i, 2) && $past(nrst_i)
    && !$past(a_if.wr_data) |-> port_a_data_o == 8'hff)
    else $error("port a latch not high after reset");
endmodule

// ==== bench/gpw_pin_model.sv ====
`timescale 1ns/1ps
module gpw_pin_model #(
  parameter int W = 8
) (
  // clock
  input wire logic clk_i,
  // design side of the pins
  input wire logic [W-1:0] pin_o_i,
  input wire logic [W-1:0] pin_oe_i,
  input wire logic [W-1:0] pin_pull_i,
  // external source set by the bench
  input wire logic [W-1:0] ext_val_i,
  input wire logic [W-1:0] ext_en_i,
  // resolved line level
  output logic [W-1:0] level_o
);
  logic [W-1:0] float_reg;
  initial float_reg = '0;
  // a floating line without pull-high flips every cycle, so a stale value cannot pass
  always @(posedge clk_i) float_reg <= ~float_reg;
  // external level changes only off the read edge and is held for cycles
  // device drive wins, then the external source, then the pull-high
  always_comb
    for (int k = 0; k < W; k++)
      level_o[k] = pin_oe_i[k] ? pin_o_i[k] :
                   ext_en_i[k] ? ext_val_i[k] :
                   pin_pull_i[k] ? 1'b1 : float_reg[k];
endmodule

// ==== bench/bidir_port_with_wakeup_tb_top.sv ====
`timescale 1ns/1ps
module bidir_port_with_wakeup_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, bop = 1'b0, rd = 1'b0, bval = 1'b0, halt = 1'b0, wake, mfreq;
  logic [2:0] bidx = 3'h0;
  logic [3:0] pull = 4'h0;
  logic [7:0] a_x = 8'hff, c_x = 8'hff, d_x = 8'ha3;
  logic [3:0] e_x = 4'h5;
  logic [7:0] a_en = 8'hff, c_en = 8'hf3, d_en = 8'hff;
  logic [3:0] e_en = 4'hf;
  logic [7:0] a_i, a_o, a_oe, a_pu, c_i, c_o, c_oe, c_pu, d_i, d_o, d_oe, d_pu;
  logic [3:0] e_i, e_o, e_oe, e_pu;
  int n_fail = 0;
  int check_count = 0;
  localparam logic [7:0] RST_EXP [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'ha3,
                                          8'hff, 8'h05, 8'h0f, 8'h00, 8'h00};

  initial forever #4 clk_i = ~clk_i;

  gpw_port_top #(.PE_W(4)) gpw_port_top_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
    .sfr_bitop_i(bop), .sfr_bit_idx_i(bidx), .sfr_bit_val_i(bval), .sfr_rd_i(rd),
    .sfr_rdata_o(rdata), .pull_opt_i(pull), .halt_i(halt), .wake_o(wake), .mf_req_o(mfreq),
    .port_a_data_i(a_i), .port_a_data_o(a_o), .port_a_data_oe_o(a_oe), .port_a_pull_o(a_pu),
    .port_c_data_i(c_i), .port_c_data_o(c_o), .port_c_data_oe_o(c_oe), .port_c_pull_o(c_pu),
    .port_d_data_i(d_i), .port_d_data_o(d_o), .port_d_data_oe_o(d_oe), .port_d_pull_o(d_pu),
    .port_e_data_i(e_i), .port_e_data_o(e_o), .port_e_data_oe_o(e_oe), .port_e_pull_o(e_pu));
  gpw_pin_model #(.W(8)) gpw_pin_model_a_i (.clk_i(clk_i), .pin_o_i(a_o), .pin_oe_i(a_oe),
    .pin_pull_i(a_pu), .ext_val_i(a_x), .ext_en_i(a_en), .level_o(a_i));
  gpw_pin_model #(.W(8)) gpw_pin_model_c_i (.clk_i(clk_i), .pin_o_i(c_o), .pin_oe_i(c_oe),
    .pin_pull_i(c_pu), .ext_val_i(c_x), .ext_en_i(c_en), .level_o(c_i));
  gpw_pin_model #(.W(8)) gpw_pin_model_d_i (.clk_i(clk_i), .pin_o_i(d_o), .pin_oe_i(d_oe),
    .pin_pull_i(d_pu), .ext_val_i(d_x), .ext_en_i(d_en), .level_o(d_i));
  gpw_pin_model #(.W(4)) gpw_pin_model_e_i (.clk_i(clk_i), .pin_o_i(e_o), .pin_oe_i(e_oe),
    .pin_pull_i(e_pu), .ext_val_i(e_x), .ext_en_i(e_en), .level_o(e_i));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // kind 1 write, 2 single-bit (index d[2:0], value d[3]), 3 read
  task automatic xfer(input logic [7:0] a, input logic [1:0] kind, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    bidx <= d[2:0];
    bval <= d[3];
    wr <= (kind == 2'd1);
    bop <= (kind == 2'd2);
    rd <= (kind == 2'd3);
    @(posedge clk_i);
    wr <= 1'b0;
    bop <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    xfer(a, 2'd3, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic watch_wake(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      if (wake === 1'b1)
        seen = 1'b1;
    end
    chk({7'h0, seen}, {7'h0, exp});
  endtask

  task automatic t_reset();
    cyc(3);
    chk(a_oe | c_oe | d_oe | {4'h0, e_oe}, 8'h00);
    chk(a_o, 8'hff);
    for (int i = 0; i < 10; i++)
      rdchk(i[7:0], RST_EXP[i]);
    xfer(8'h0a, 2'd1, 8'hff);
    rdchk(8'h0a, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_first_drive();
    xfer(8'h07, 2'd1, 8'h00);
    cyc(2);
    chk({4'h0, e_oe}, 8'h0f);
    chk({4'h0, e_o}, 8'h0f);
    $display("test first drive done");
  endtask

  task automatic t_mixed();
    xfer(8'h05, 2'd1, 8'h0f);
    xfer(8'h04, 2'd1, 8'h5a);
    cyc(3);
    chk(d_oe, 8'hf0);
    rdchk(8'h04, 8'h53);
    @(posedge clk_i) d_x <= 8'hac;
    cyc(20);
    chk(d_o, 8'h5a);
    rdchk(8'h04, 8'h5c);
    xfer(8'h04, 2'd2, 8'h06);
    cyc(2);
    rdchk(8'h04, 8'h1c);
    chk(d_o, 8'h1c);
    $display("test mixed port done");
  endtask

  task automatic t_pull();
    @(posedge clk_i) pull <= 4'b1101;
    cyc(3);
    chk(a_pu, 8'hff);
    chk(d_pu, 8'h0f);
    chk(c_pu | {4'h0, e_pu}, 8'h00);
    // disable port a's external source so the lines float: only the pull-high can show ones
    @(posedge clk_i) a_en <= 8'h00;
    a_x <= 8'h00;
    cyc(4);
    rdchk(8'h00, 8'hff);
    @(posedge clk_i) a_en <= 8'hff;
    a_x <= 8'hff;
    cyc(4);
    @(posedge clk_i) pull <= 4'b0010;
    cyc(3);
    chk(c_pu, 8'hf3);
    chk(a_pu | d_pu, 8'h00);
    $display("test pull done");
  endtask

  task automatic t_opendrain();
    xfer(8'h03, 2'd1, 8'h00);
    xfer(8'h02, 2'd1, 8'h08);
    cyc(3);
    chk(c_oe & 8'h0c, 8'h04);
    chk(c_o & 8'h0c, 8'h00);
    rdchk(8'h02, 8'h08);
    $display("test open drain done");
  endtask

  task automatic t_wake();
    xfer(8'h09, 2'd2, 8'h0a);
    rdchk(8'h09, 8'h04);
    @(posedge clk_i) halt <= 1'b1;
    cyc(4);
    @(posedge clk_i) a_x <= 8'hf7;
    watch_wake(10, 1'b0);
    @(posedge clk_i) a_x <= 8'hf3;
    watch_wake(10, 1'b1);
    @(posedge clk_i) a_x <= 8'hff;
    halt <= 1'b0;
    cyc(4);
    @(posedge clk_i) a_x <= 8'hfb;
    watch_wake(10, 1'b0);
    $display("test wake done");
  endtask

  task automatic t_pin_irq();
    xfer(8'h03, 2'd1, 8'hff);
    xfer(8'h08, 2'd1, 8'h05);
    cyc(4);
    @(posedge clk_i) c_x <= 8'hdf;
    cyc(5);
    rdchk(8'h08, 8'h05);
    chk({7'h0, mfreq}, 8'h00);
    @(posedge clk_i) c_x <= 8'hde;
    cyc(5);
    rdchk(8'h08, 8'h15);
    chk({7'h0, mfreq}, 8'h01);
    @(posedge clk_i) c_x <= 8'h5e;
    cyc(5);
    rdchk(8'h08, 8'h55);
    xfer(8'h08, 2'd1, 8'h45);
    cyc(2);
    rdchk(8'h08, 8'h45);
    chk({7'h0, mfreq}, 8'h01);
    xfer(8'h08, 2'd1, 8'h05);
    cyc(2);
    rdchk(8'h08, 8'h05);
    chk({7'h0, mfreq}, 8'h00);
    $display("test pin interrupt done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_first_drive();
    t_mixed();
    t_pull();
    t_opendrain();
    t_wake();
    t_pin_irq();
    give_verdict();
  end

  // a hang anywhere ends in the same report
  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule
